// File: src/bus_ctrl_pkg.sv
// Shared constants for the external bus controller: register map, config
// bits, pin positions, address windows and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package bus_ctrl_pkg;

  // Register bus geometry
  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;

  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] REG_CHIP_CONFIG    = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_PIN_FUNCTION   = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_PORT_OUTPUT    = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_PORT_DIRECTION = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] REG_PORT_INPUT     = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS         = 8'h14;

  // Fields of chip_config_byte
  localparam int unsigned CFG_W            = 4;
  localparam int unsigned CFG_STROBE_VALID = 0;
  localparam int unsigned CFG_WIDE         = 1;
  localparam int unsigned CFG_DYN          = 2;
  localparam int unsigned CFG_SPLIT_STORE  = 3;
  localparam logic [CFG_W-1:0] CFG_RESET   = 4'h0;

  // Control pin positions
  localparam int unsigned PIN_W         = 8;
  localparam int unsigned PIN_STROBE    = 0;
  localparam int unsigned PIN_FETCH     = 1;
  localparam int unsigned PIN_STORE     = 2;
  localparam int unsigned PIN_READ      = 3;
  localparam int unsigned PIN_HIGH_BYTE = 5;
  localparam int unsigned PIN_READY     = 6;
  localparam int unsigned PIN_SIZE      = 7;
  localparam logic [PIN_W-1:0] FUNC_OUT_MASK = 8'h2f;
  localparam logic [PIN_W-1:0] FUNC_MASK     = 8'hef;

  // Status fields
  localparam int unsigned STAT_W    = 3;
  localparam int unsigned STAT_EXT  = 0;
  localparam int unsigned STAT_PROG = 1;
  localparam int unsigned STAT_BUSY = 2;

  // On-chip program memory window
  localparam logic [15:0] INTERNAL_LO = 16'h2000;
  localparam logic [15:0] INTERNAL_HI = 16'h5fff;

  // Cycles spent filling the strap synchronisers after reset
  localparam logic [1:0] INIT_WAIT = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bus cycle sequencer
  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_ADDR, ST_DATA, ST_DONE} bus_state_e;

endpackage

// File: src/cfg_if.sv
// Carrier between the register slave and the bus sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface cfg_if;
  import bus_ctrl_pkg::*;
  logic [CFG_W-1:0]  chip_config;
  logic [PIN_W-1:0]  pin_function;
  logic [PIN_W-1:0]  port_output;
  logic [PIN_W-1:0]  port_direction;
  logic [PIN_W-1:0]  port_input;
  logic [STAT_W-1:0] status;
  modport regs (output chip_config, pin_function, port_output, port_direction,
                input port_input, status);
  modport core (input chip_config, pin_function, port_output, port_direction,
                output port_input, status);
endinterface
`default_nettype wire

// File: src/bus_registers.sv
// AXI4-Lite register slave holding bus setup and showing sequencer state.
// Assumes one outstanding write and one outstanding read from the master.
`timescale 1ns/1ns
`default_nettype none
module bus_registers
  import bus_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  reset_n_in,
  // Write channels
  input  wire logic [AXI_ADDR_W-1:0] axi_awaddr_in,
  input  wire logic                  axi_awvalid_in,
  output var  logic                  axi_awready_out,
  input  wire logic [AXI_DATA_W-1:0] axi_wdata_in,
  input  wire logic [3:0]            axi_wstrb_in,
  input  wire logic                  axi_wvalid_in,
  output var  logic                  axi_wready_out,
  output var  logic [1:0]            axi_bresp_out,
  output var  logic                  axi_bvalid_out,
  input  wire logic                  axi_bready_in,
  // Read channels
  input  wire logic [AXI_ADDR_W-1:0] axi_araddr_in,
  input  wire logic                  axi_arvalid_in,
  output var  logic                  axi_arready_out,
  output var  logic [AXI_DATA_W-1:0] axi_rdata_out,
  output var  logic [1:0]            axi_rresp_out,
  output var  logic                  axi_rvalid_out,
  input  wire logic                  axi_rready_in,
  // Setup and state
  cfg_if.regs                        cfg
);
  typedef struct packed {
    logic                  aw_held;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  w_held;
    logic [AXI_DATA_W-1:0] wdata;
    logic                  wlane0;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic [CFG_W-1:0]      chip_config;
    logic [PIN_W-1:0]      func;
    logic [PIN_W-1:0]      pout;
    logic [PIN_W-1:0]      pdir;
  } regs_s;

  regs_s s;
  regs_s n;

  // Known word offset
  function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
    mapped = (a == REG_CHIP_CONFIG) || (a == REG_PIN_FUNCTION) || (a == REG_PORT_OUTPUT)
          || (a == REG_PORT_DIRECTION) || (a == REG_PORT_INPUT) || (a == REG_STATUS);
  endfunction

  // Channel handshakes, register writes and read data
  always_comb
  begin
    n = s;
    if (axi_bready_in && s.bvalid)
      n.bvalid = 1'b0;
    if (axi_rready_in && s.rvalid)
      n.rvalid = 1'b0;
    if (axi_awvalid_in && s.awready)
    begin
      n.aw_held = 1'b1;
      n.awaddr = {axi_awaddr_in[AXI_ADDR_W-1:2], 2'b00};
    end
    if (axi_wvalid_in && s.wready)
    begin
      n.w_held = 1'b1;
      n.wdata = axi_wdata_in;
      n.wlane0 = axi_wstrb_in[0];
    end
    if (n.aw_held && n.w_held && !n.bvalid)
    begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = mapped(n.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (n.wlane0)
      begin
        case (n.awaddr)
          REG_CHIP_CONFIG:    n.chip_config = n.wdata[CFG_W-1:0];
          REG_PIN_FUNCTION:   n.func = n.wdata[PIN_W-1:0] & FUNC_MASK;
          REG_PORT_OUTPUT:    n.pout = n.wdata[PIN_W-1:0];
          REG_PORT_DIRECTION: n.pdir = n.wdata[PIN_W-1:0];
          default:            n.pdir = n.pdir;
        endcase
      end
    end
    if (axi_arvalid_in && s.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = '0;
      n.rresp = mapped({axi_araddr_in[AXI_ADDR_W-1:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      case ({axi_araddr_in[AXI_ADDR_W-1:2], 2'b00})
        REG_CHIP_CONFIG:    n.rdata[CFG_W-1:0] = s.chip_config;
        REG_PIN_FUNCTION:   n.rdata[PIN_W-1:0] = s.func;
        REG_PORT_OUTPUT:    n.rdata[PIN_W-1:0] = s.pout;
        REG_PORT_DIRECTION: n.rdata[PIN_W-1:0] = s.pdir;
        REG_PORT_INPUT:     n.rdata[PIN_W-1:0] = cfg.port_input;
        REG_STATUS:         n.rdata[STAT_W-1:0] = cfg.status;
        default:            n.rdata = '0;
      endcase
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;
    n.arready = !n.rvalid;
  end

  // State register
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      s <= '0;
      s.chip_config <= CFG_RESET;
    end
    else
      s <= n;
  end

  // Outputs from state
  assign axi_awready_out = s.awready;
  assign axi_wready_out = s.wready;
  assign axi_bvalid_out = s.bvalid;
  assign axi_bresp_out = s.bresp;
  assign axi_arready_out = s.arready;
  assign axi_rvalid_out = s.rvalid;
  assign axi_rdata_out = s.rdata;
  assign axi_rresp_out = s.rresp;
  assign cfg.chip_config = s.chip_config;
  assign cfg.pin_function = s.func;
  assign cfg.port_output = s.pout;
  assign cfg.port_direction = s.pdir;

endmodule // bus_registers
`default_nettype wire

// File: src/external_memory_bus_control.sv
// External memory bus controller: sequences multiplexed 16-bit address/data
// cycles, drives strobes, byte enables, fetch flag and bus clock, and picks
// internal or external memory from the select strap taken after reset.
// Assumes a CPU request port on clock_in and an address latch on the pins.
// Contract
// - Address strobe pin is either latch-enable pulse or address-valid, chosen by config.
// - Address is valid while the strobe falls, so a latch can capture it.
// - Address-valid form is low during access, high at end of cycle.
// - Strobe moves only for external accesses, idle during internal ones.
// - High-byte-enable form goes low on external writes using the upper byte.
// - High-byte-store form goes low on external 16-bit writes of an odd byte or a word.
// - High byte pin asserts only on external writes, never reads or internal.
// - Config bits 1 and 2 both set make the size pin pick cycle width.
// - Size pin low means 8-bit cycle, high means 16-bit; device obeys.
// - Fetch indicator is high through external fetch cycles, low otherwise.
// - Bus clock runs at half the oscillator rate, 50 percent duty.
// - Select strap low sends every access to the external bus.
// - Select strap high serves 2000h to 5fffh on chip, rest external.
// - Programming level on select strap starts programming mode; strap latched at reset.
// - Each bus control pin works as plain port pin when function off; size pin still picks cycle width when config bits 1 and 2 set.
// - Read strobe is low only during external read cycles.
// - Store strobe pulses on every external write; split form only for writes using the low byte.
// - Ready low inserts wait states; cycle proceeds at bus clock rise seeing ready.
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module external_memory_bus_control
  import bus_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  reset_n_in,
  // AXI4-Lite register slave
  input  wire logic [AXI_ADDR_W-1:0] axi_awaddr_in,
  input  wire logic                  axi_awvalid_in,
  output var  logic                  axi_awready_out,
  input  wire logic [AXI_DATA_W-1:0] axi_wdata_in,
  input  wire logic [3:0]            axi_wstrb_in,
  input  wire logic                  axi_wvalid_in,
  output var  logic                  axi_wready_out,
  output var  logic [1:0]            axi_bresp_out,
  output var  logic                  axi_bvalid_out,
  input  wire logic                  axi_bready_in,
  input  wire logic [AXI_ADDR_W-1:0] axi_araddr_in,
  input  wire logic                  axi_arvalid_in,
  output var  logic                  axi_arready_out,
  output var  logic [AXI_DATA_W-1:0] axi_rdata_out,
  output var  logic [1:0]            axi_rresp_out,
  output var  logic                  axi_rvalid_out,
  input  wire logic                  axi_rready_in,
  // CPU request and answer
  input  wire logic                  req_valid_in,
  output var  logic                  req_ready_out,
  input  wire logic [15:0]           req_addr_in,
  input  wire logic                  req_write_in,
  input  wire logic                  req_word_in,
  input  wire logic                  req_fetch_in,
  input  wire logic [15:0]           req_wdata_in,
  output var  logic                  resp_valid_out,
  output var  logic [15:0]           resp_rdata_out,
  output var  logic                  resp_internal_out,
  // Straps
  input  wire logic                  external_access_select_in,
  input  wire logic                  programming_level_in,
  output var  logic                  programming_mode_out,
  // Multiplexed address/data pins
  input  wire logic [15:0]           ad_in,
  output var  logic [15:0]           ad_out,
  output var  logic [1:0]            ad_oe_out,
  // Bus control and port pins
  input  wire logic [PIN_W-1:0]      ctrl_pin_in,
  output var  logic [PIN_W-1:0]      ctrl_pin_out,
  output var  logic [PIN_W-1:0]      ctrl_pin_oe_out,
  output var  logic                  bus_clock_output_out
);
  typedef struct packed {
    bus_state_e       st;
    logic             half;
    logic             bus_clk;
    logic [1:0]       init_cnt;
    logic             ea_s1;
    logic             ea_s2;
    logic             pg_s1;
    logic             pg_s2;
    logic             ea_latched;
    logic             prog_mode;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [15:0]      ad_s1;
    logic [15:0]      ad_s2;
    logic [15:0]      addr;
    logic [15:0]      wdata;
    logic             wr;
    logic             word;
    logic             fetch;
    logic             wide;
    logic             second;
    logic [15:0]      rdata;
    logic             req_ready;
    logic             resp_valid;
    logic             resp_internal;
    logic [15:0]      ad_out;
    logic [1:0]       ad_oe;
    logic [PIN_W-1:0] pin_out;
    logic [PIN_W-1:0] pin_oe;
  } core_s;

  core_s            s;
  core_s            n;
  logic [PIN_W-1:0] fn;
  logic [1:0]       lanes;
  logic             active;
  logic             data_ph;
  logic             ready_now;
  logic             size_now;

  cfg_if cfg ();

  // Register slave
  bus_registers regs_i (
    .clock_in        (clock_in),
    .reset_n_in      (reset_n_in),
    .axi_awaddr_in   (axi_awaddr_in),
    .axi_awvalid_in  (axi_awvalid_in),
    .axi_awready_out (axi_awready_out),
    .axi_wdata_in    (axi_wdata_in),
    .axi_wstrb_in    (axi_wstrb_in),
    .axi_wvalid_in   (axi_wvalid_in),
    .axi_wready_out  (axi_wready_out),
    .axi_bresp_out   (axi_bresp_out),
    .axi_bvalid_out  (axi_bvalid_out),
    .axi_bready_in   (axi_bready_in),
    .axi_araddr_in   (axi_araddr_in),
    .axi_arvalid_in  (axi_arvalid_in),
    .axi_arready_out (axi_arready_out),
    .axi_rdata_out   (axi_rdata_out),
    .axi_rresp_out   (axi_rresp_out),
    .axi_rvalid_out  (axi_rvalid_out),
    .axi_rready_in   (axi_rready_in),
    .cfg             (cfg.regs)
  );

  // On-chip window decode
  function automatic logic is_internal(input logic [15:0] a, input logic ea);
    is_internal = ea && (a >= INTERNAL_LO) && (a <= INTERNAL_HI);
  endfunction

  // Byte lanes a cycle uses: {high, low}
  function automatic logic [1:0] lanes_used(input logic wide, input logic word,
                                            input logic a0);
    if (wide)
      lanes_used = {word || a0, word || !a0};
    else
      lanes_used = 2'b01;
  endfunction

  // Effective ready and size from synchronised pins
  assign ready_now = cfg.pin_function[PIN_READY] ? s.pin_s2[PIN_READY] : 1'b1;
  assign size_now = (cfg.chip_config[CFG_WIDE] && cfg.chip_config[CFG_DYN])
                  ? s.pin_s2[PIN_SIZE] : cfg.chip_config[CFG_WIDE];

  // Sequencer, synchronisers and pin drive
  always_comb
  begin
    n = s;
    n.resp_valid = 1'b0;
    n.resp_internal = 1'b0;
    n.bus_clk = ~s.bus_clk;
    n.ea_s1 = external_access_select_in;
    n.ea_s2 = s.ea_s1;
    n.pg_s1 = programming_level_in;
    n.pg_s2 = s.pg_s1;
    n.pin_s1 = ctrl_pin_in;
    n.pin_s2 = s.pin_s1;
    n.ad_s1 = ad_in;
    n.ad_s2 = s.ad_s1;
    case (s.st)
      ST_INIT:
      begin
        n.init_cnt = s.init_cnt + 2'h1;
        if (s.init_cnt == INIT_WAIT)
        begin
          n.ea_latched = s.ea_s2;
          n.prog_mode = s.pg_s2;
          n.st = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (req_valid_in && s.req_ready)
        begin
          n.addr = req_word_in ? {req_addr_in[15:1], 1'b0} : req_addr_in;
          n.wdata = req_wdata_in;
          n.wr = req_write_in;
          n.word = req_word_in;
          n.fetch = req_fetch_in;
          n.second = 1'b0;
          n.rdata = '0;
          n.half = 1'b0;
          if (is_internal(req_addr_in, s.ea_latched))
          begin
            n.resp_valid = 1'b1;
            n.resp_internal = 1'b1;
          end
          else
            n.st = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        n.half = 1'b1;
        if (s.half)
        begin
          n.st = ST_DATA;
          n.half = 1'b0;
          n.wide = size_now;
        end
      end
      ST_DATA:
      begin
        n.half = 1'b1;
        if (s.half && !s.bus_clk && ready_now)
          n.st = ST_DONE;
      end
      ST_DONE:
      begin
        if (!s.wr)
        begin
          if (s.wide && s.word)
            n.rdata = s.ad_s2;
          else if (s.wide)
            n.rdata[7:0] = s.addr[0] ? s.ad_s2[15:8] : s.ad_s2[7:0];
          else if (s.second)
            n.rdata[15:8] = s.ad_s2[7:0];
          else
            n.rdata[7:0] = s.ad_s2[7:0];
        end
        if (!s.wide && s.word && !s.second)
        begin
          n.second = 1'b1;
          n.addr = {s.addr[15:1], 1'b1};
          n.half = 1'b0;
          n.st = ST_ADDR;
        end
        else
        begin
          n.resp_valid = 1'b1;
          n.st = ST_IDLE;
        end
      end
      default:
        n.st = ST_INIT;
    endcase
    n.req_ready = (n.st == ST_IDLE) && !n.resp_valid;

    // Bus function levels for the coming cycle
    lanes = lanes_used(n.wide, n.word, n.addr[0]);
    active = (n.st == ST_ADDR) || (n.st == ST_DATA);
    data_ph = (n.st == ST_DATA);
    fn = '0;
    fn[PIN_STROBE] = cfg.chip_config[CFG_STROBE_VALID] ? !active
                   : ((n.st == ST_ADDR) && !n.half);
    fn[PIN_FETCH] = active && n.fetch;
    fn[PIN_STORE] = !(data_ph && n.wr
                    && (!cfg.chip_config[CFG_SPLIT_STORE] || lanes[0]));
    fn[PIN_READ] = !(data_ph && !n.wr);
    fn[PIN_HIGH_BYTE] = !(data_ph && n.wr && lanes[1]);

    // Address during the address phase, write data on used lanes after
    if (n.st == ST_ADDR)
    begin
      n.ad_out = n.addr;
      n.ad_oe = 2'b11;
    end
    else if (data_ph && n.wr)
    begin
      if (n.wide && n.word)
        n.ad_out = n.wdata;
      else if (n.second)
        n.ad_out = {n.wdata[15:8], n.wdata[15:8]};
      else
        n.ad_out = {n.wdata[7:0], n.wdata[7:0]};
      n.ad_oe = lanes;
    end
    else
      n.ad_oe = 2'b00;

    // Bus function or plain port per pin
    for (int i = 0; i < PIN_W; i++)
    begin
      if (cfg.pin_function[i])
      begin
        n.pin_out[i] = FUNC_OUT_MASK[i] ? fn[i] : cfg.port_output[i];
        n.pin_oe[i] = FUNC_OUT_MASK[i];
      end
      else
      begin
        n.pin_out[i] = cfg.port_output[i];
        n.pin_oe[i] = cfg.port_direction[i];
      end
    end
  end

  // State register
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
      s <= '0;
    else
      s <= n;
  end

  // Outputs and state shown to software
  assign req_ready_out = s.req_ready;
  assign resp_valid_out = s.resp_valid;
  assign resp_rdata_out = s.rdata;
  assign resp_internal_out = s.resp_internal;
  assign programming_mode_out = s.prog_mode;
  assign ad_out = s.ad_out;
  assign ad_oe_out = s.ad_oe;
  assign ctrl_pin_out = s.pin_out;
  assign ctrl_pin_oe_out = s.pin_oe;
  assign bus_clock_output_out = s.bus_clk;
  assign cfg.port_input = s.pin_s2;
  assign cfg.status = {s.st != ST_IDLE, s.prog_mode, s.ea_latched};

  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  chk_adv_low_access: assert property (
    (cfg.chip_config[CFG_STROBE_VALID] && cfg.pin_function[PIN_STROBE] && s.st == ST_DATA)
    |-> !ctrl_pin_out[PIN_STROBE])
    else $error("address valid strobe high during access");

  chk_adv_end_high: assert property (
    (cfg.chip_config[CFG_STROBE_VALID] && cfg.pin_function[PIN_STROBE] && s.st == ST_DONE)
    |-> ctrl_pin_out[PIN_STROBE])
    else $error("address valid strobe not high at end of cycle");

  chk_ale_addr_valid: assert property (
    (!cfg.chip_config[CFG_STROBE_VALID] && $fell(s.pin_out[PIN_STROBE]) && $past(s.pin_oe[PIN_STROBE]))
    |-> (s.st == ST_ADDR && s.ad_oe == 2'b11))
    else $error("latch strobe fell without address on bus");

  chk_internal_quiet: assert property (
    s.resp_internal |-> (s.st == ST_IDLE && $past(s.st) == ST_IDLE))
    else $error("internal access moved the bus sequencer");

  chk_high_byte_write: assert property (
    ($past(cfg.pin_function[PIN_HIGH_BYTE]) && !ctrl_pin_out[PIN_HIGH_BYTE])
    |-> (s.st == ST_DATA && s.wr && s.wide))
    else $error("high byte pin low outside a wide write");

  chk_read_strobe: assert property (
    ($past(cfg.pin_function[PIN_READ]) && !ctrl_pin_out[PIN_READ])
    |-> (s.st == ST_DATA && !s.wr))
    else $error("read strobe low outside a read");

  chk_fetch_level: assert property (
    (cfg.pin_function[PIN_FETCH] && (s.st == ST_ADDR || s.st == ST_DATA))
    |-> (ctrl_pin_out[PIN_FETCH] == s.fetch))
    else $error("fetch indicator wrong during bus cycle");

  chk_bus_clock_half: assert property (
    bus_clock_output_out |=> !bus_clock_output_out ##1 bus_clock_output_out)
    else $error("bus clock not at half rate");

  chk_wait_states: assert property (
    (s.st == ST_DATA && s.half && !ready_now) |=> (s.st == ST_DATA))
    else $error("cycle ended while ready low");

  chk_narrow_lanes: assert property (
    (s.st == ST_DATA && !s.wide) |-> !s.ad_oe[1])
    else $error("narrow cycle drove high byte lines");

  chk_ext_all: assert property (
    (s.st == ST_IDLE && !s.ea_latched) |-> !s.resp_internal)
    else $error("access kept internal with strap low");

  cov_ext_read: cover property (s.st == ST_DATA && !s.wr ##[1:40] s.resp_valid);
  cov_ext_write: cover property (s.st == ST_DATA && s.wr && s.wide && s.word);
  cov_narrow_word: cover property (s.st == ST_ADDR && s.second);
  cov_internal: cover property (s.resp_internal);

endmodule // external_memory_bus_control
`default_nettype wire

// File: verif/ext_memory.sv
// Byte-wide external memory behind an address latch.
// Assumes pin levels with pull-ups applied; released bus reads all ones.
`timescale 1ns/1ns
`default_nettype none
module ext_memory
  import bus_ctrl_pkg::*;
(
  // Pin levels in
  input  wire logic             clock_in,
  input  wire logic [15:0]      ad_in,
  input  wire logic [PIN_W-1:0] pin_in,
  // Read data out
  output var  logic [15:0]      ad_out
);
  logic [7:0] mem [0:255];
  logic [7:0] addr;
  logic       strobe_q;
  // Latch on strobe fall, store while strobes low
  always @(posedge clock_in)
  begin
    strobe_q <= pin_in[PIN_STROBE];
    if (strobe_q && !pin_in[PIN_STROBE]) addr <= ad_in[7:0];
    if (!pin_in[PIN_STORE]) mem[addr] <= ad_in[7:0];
    if (!pin_in[PIN_HIGH_BYTE]) mem[addr | 8'h01] <= ad_in[15:8];
  end
  // Drive only while read strobe low
  assign ad_out = !pin_in[PIN_READ] ? {mem[addr | 8'h01], mem[addr]} : 16'hffff;
endmodule // ext_memory
`default_nettype wire

// File: verif/external_memory_bus_control_bench.sv
// Bench: AXI4-Lite register tasks and CPU requests into a memory model.
// Assumes ext_memory on the pins; released lines pulled up.
`timescale 1ns/1ns
`default_nettype none
module external_memory_bus_control_bench;
  import bus_ctrl_pkg::*;
  logic        clock_in = 0;
  logic        reset_n_in = 0;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0;
  logic        wvalid = 0;
  logic        arvalid = 0;
  logic        req_valid = 0;
  logic        req_write = 0;
  logic [15:0] req_addr = 0;
  logic [15:0] req_wdata = 0;
  logic        strap = 1;
  logic        prog = 0;
  logic [1:0]  rs = 2'b11;
  logic [3:0]  wt = 0;
  wire logic awready, wready, bvalid, arready, rvalid, req_ready, resp_valid, resp_int, bco, pm;
  wire logic [1:0]  bresp, rresp, ad_oe;
  wire logic [31:0] rdata;
  wire logic [15:0] rdq, ad_o, mem_q;
  wire logic [7:0]  pin_o, pin_oe;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [31:0] d;
  logic [1:0]  r;
  logic [15:0] q;
  logic        i;
  logic        b;
  logic [15:0] win [4] = '{16'h1ffe, 16'h2000, 16'h5ffe, 16'h6000};
  // Wire levels seen by both sides
  wire logic [7:0]  pin_lvl = (pin_o & pin_oe) | ~pin_oe;
  wire logic [15:0] ad_lvl = {ad_oe[1] ? ad_o[15:8] : mem_q[15:8], ad_oe[0] ? ad_o[7:0] : mem_q[7:0]};
  wire logic        rdy = rs[0] | (wt > 4'h3);
  external_memory_bus_control external_memory_bus_control_i (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid),
    .axi_awready_out(awready), .axi_wdata_in(wdata), .axi_wstrb_in(4'hf), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_bresp_out(bresp), .axi_bvalid_out(bvalid), .axi_bready_in(1'b1),
    .axi_araddr_in(araddr), .axi_arvalid_in(arvalid), .axi_arready_out(arready),
    .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rvalid_out(rvalid), .axi_rready_in(1'b1),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_addr_in(req_addr),
    .req_write_in(req_write), .req_word_in(!req_addr[0]), .req_fetch_in(!req_write),
    .req_wdata_in(req_wdata),
    .resp_valid_out(resp_valid), .resp_rdata_out(rdq), .resp_internal_out(resp_int),
    .external_access_select_in(strap), .programming_level_in(prog), .programming_mode_out(pm),
    .ad_in(ad_lvl), .ad_out(ad_o), .ad_oe_out(ad_oe), .ctrl_pin_in({rs[1], rdy, pin_lvl[5:0]}),
    .ctrl_pin_out(pin_o), .ctrl_pin_oe_out(pin_oe), .bus_clock_output_out(bco));
  ext_memory ext_memory_i (.clock_in(clock_in), .ad_in(ad_lvl), .pin_in(pin_lvl), .ad_out(mem_q));
  // Clock and hang limit
  always #5 clock_in = ~clock_in;
  // Memory ready low for the first cycles of each read or store strobe
  always @(posedge clock_in) wt <= (pin_lvl[5] & pin_lvl[3] & pin_lvl[2]) ? 4'h0 : wt + 4'h1;
  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin errors++; $display("ERROR %s expected %h seen %h", n, e, g); end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'b11};
    do
    begin
      @(posedge clock_in);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    while (!bvalid);
    r = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    {araddr, arvalid} <= {a, 1'b1};
    do
    begin
      @(posedge clock_in);
      if (arready) arvalid <= 0;
    end
    while (!rvalid);
    {d, r} = {rdata, rresp};
  endtask
  task automatic cpu(input logic [15:0] a, input logic w, input logic [15:0] v);
    {req_valid, req_addr, req_write, req_wdata} <= {1'b1, a, w, v};
    do @(posedge clock_in); while (!req_ready);
    req_valid <= 0;
    do @(posedge clock_in); while (!resp_valid);
    {q, i} = {rdq, resp_int};
  endtask
  task automatic rst;
    reset_n_in <= 0;
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1;
    repeat (6) @(posedge clock_in);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst;
    axr(REG_CHIP_CONFIG);
    chk("config_reset", CFG_RESET, d);
    axr(8'h18);
    chk("unmapped_rresp", RESP_SLVERR, r);
    axw(8'h18, 32'h0);
    chk("unmapped_bresp", RESP_SLVERR, r);
    axw(REG_STATUS, 32'h7);
    axr(REG_STATUS);
    chk("status", 32'h1, d);
    axw(REG_CHIP_CONFIG, 32'h2);
    axw(REG_PIN_FUNCTION, 32'hff);
    axr(REG_PIN_FUNCTION);
    chk("pin_function", FUNC_MASK, d);
    $display("registers done");
    repeat (6)
    begin
      b = bco;
      @(posedge clock_in);
      chk("bus_clock", !b, bco);
    end
    for (int k = 0; k < 4; k++)
    begin
      cpu(win[k], 0, 0);
      chk("internal", 4'b0110 >> k & 1, i);
    end
    cpu(16'h0140, 1, 16'hbeef);
    cpu(16'h6010, 1, 16'h1234);
    cpu(16'h0140, 0, 0);
    chk("word_low", 16'hbeef, q);
    cpu(16'h6010, 0, 0);
    chk("word_high", 16'h1234, q);
    axw(REG_CHIP_CONFIG, 32'h6);
    rs <= 2'b00;
    cpu(16'h0150, 1, 16'ha55a);
    cpu(16'h0150, 0, 0);
    chk("narrow_word", 16'ha55a, q);
    axw(REG_CHIP_CONFIG, 32'hb);
    cpu(16'h0162, 1, 16'h5aa5);
    cpu(16'h0163, 1, 16'h0077);
    cpu(16'h0162, 0, 0);
    chk("split_odd", 16'h77a5, q);
    $display("data tests done");
    {strap, prog} <= 2'b01;
    rst;
    axr(REG_STATUS);
    chk("status_strap", 32'h2, d);
    chk("prog_mode", 1, pm);
    axw(REG_CHIP_CONFIG, 32'h2);
    axw(REG_PIN_FUNCTION, 32'hff);
    cpu(16'h2000, 0, 0);
    chk("all_external", 0, i);
    $display("strap test done");
    print_verdict;
  end
endmodule // external_memory_bus_control_bench
`default_nettype wire
